// [gpio_cmd_pkg.sv]
// shared constants and carrier types for the packet-driven i/o port
package gpio_cmd_pkg;
    localparam int IO_WIDTH = 7;
    localparam int REPLY_LEN = 5;
    localparam logic [2:0] IDX_OPIF = 3'h0;
    localparam logic [2:0] IDX_SLAVE = 3'h1;
    localparam logic [2:0] IDX_LENGTH = 3'h2;
    localparam logic [2:0] IDX_REGADDR = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [7:0] OP_WRITE = 8'h10;
    localparam logic [7:0] OP_MASK = 8'h10;
    localparam logic [7:0] INTF_MASK = 8'h0f;
    localparam logic [7:0] INTF_IO = 8'h08;
    localparam logic [7:0] INTF_FOUR_WIRE_LONG = 8'h04;
    localparam logic [7:0] INTF_TWO_WIRE_FAST = 8'h02;
    localparam logic [7:0] INTF_TWO_WIRE_STD = 8'h01;
    localparam logic [7:0] INTF_FOUR_WIRE_SHORT = 8'h00;
    localparam logic [7:0] STAT_REQ_ERROR = 8'h80;
    localparam logic [7:0] STAT_INTF_ERROR = 8'h40;
    localparam logic [7:0] STAT_REQ_DONE = 8'h20;
    localparam logic [7:0] STAT_MASK = 8'he0;
    localparam logic [6:0] IO_OUT_RESET = 7'h00;
    localparam logic [6:0] IO_OE_RESET = 7'h00;

    typedef struct packed {
        logic io_line_6;
        logic io_line_5;
        logic io_line_4;
        logic io_line_3;
        logic io_line_2;
        logic io_line_1;
        logic io_line_0;
    } gpio_lines_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } pkt_byte_t;

    typedef enum logic [2:0] {
        ST_RX = 3'b001,
        ST_EXEC = 3'b010,
        ST_TX = 3'b100
    } cmd_state_t;
endpackage : gpio_cmd_pkg

// [io_line_sync.sv]
// two-flop synchroniser for the sampled i/o lines
`timescale 1ns/1ps
`default_nettype none
module io_line_sync #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // lines
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("io_line_sync: WIDTH must be at least 1");
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                end else begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2_reg;
endmodule : io_line_sync
`default_nettype wire

// [gpio_packet_command_port.sv]
// command packet interpreter driving and sampling the seven-line i/o port
`timescale 1ns/1ps
`default_nettype none
module gpio_packet_command_port #(
    parameter int IO_LINES = gpio_cmd_pkg::IO_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // command packet stream in
    input wire logic rx_valid,
    input wire gpio_cmd_pkg::pkt_byte_t rx_byte,
    output logic rx_ready,
    // reply packet stream out
    output logic tx_valid,
    output gpio_cmd_pkg::pkt_byte_t tx_byte,
    input wire logic tx_ready,
    // i/o lines
    input wire gpio_cmd_pkg::gpio_lines_t io_lines_in,
    output gpio_cmd_pkg::gpio_lines_t io_lines_out,
    output gpio_cmd_pkg::gpio_lines_t io_lines_oe
);
    import gpio_cmd_pkg::*;

    initial begin
        if (IO_LINES != IO_WIDTH) begin
            $error("gpio_packet_command_port: the data byte carries exactly seven lines");
        end
    end

    cmd_state_t state_reg;
    cmd_state_t state_next;
    logic [7:0] pkt_reg [0:REPLY_LEN-1];
    logic [7:0] reply_reg [0:REPLY_LEN-1];
    logic [2:0] rx_cnt_reg;
    logic [2:0] tx_idx_reg;
    logic [6:0] io_out_reg;
    logic [6:0] io_oe_reg;
    logic [6:0] io_sync;
    logic rx_ready_reg;
    logic tx_valid_reg;
    logic [7:0] tx_data_reg;
    logic tx_last_reg;
    logic rx_take;
    logic tx_take;
    logic [7:0] intf_code;
    logic intf_known;
    logic is_io;
    logic is_write;
    logic [7:0] status_byte;

    io_line_sync #(
        .WIDTH(IO_WIDTH)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(io_lines_in),
        .sync_out(io_sync)
    );

    assign rx_take = rx_valid && rx_ready_reg;
    assign tx_take = tx_valid_reg && tx_ready;

    // decode of the request byte; unknown upper bits make it malformed
    assign intf_code = pkt_reg[IDX_OPIF] & INTF_MASK;
    assign intf_known = ((pkt_reg[IDX_OPIF] & STAT_MASK) == 8'h00) &&
        (intf_code == INTF_IO || intf_code == INTF_FOUR_WIRE_LONG ||
         intf_code == INTF_TWO_WIRE_FAST || intf_code == INTF_TWO_WIRE_STD ||
         intf_code == INTF_FOUR_WIRE_SHORT);
    assign is_io = intf_known && (intf_code == INTF_IO);
    assign is_write = (pkt_reg[IDX_OPIF] & OP_MASK) == OP_WRITE;

    // serial engines live elsewhere, so other interfaces answer with an interface error
    always_comb begin
        if (!intf_known) begin
            status_byte = pkt_reg[IDX_OPIF] | STAT_REQ_ERROR;
        end else if (is_io) begin
            status_byte = pkt_reg[IDX_OPIF] | STAT_REQ_DONE;
        end else begin
            status_byte = pkt_reg[IDX_OPIF] | STAT_INTF_ERROR;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RX: begin
                if (rx_take && rx_byte.last) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_TX;
            end
            ST_TX: begin
                if (tx_take && tx_last_reg) begin
                    state_next = ST_RX;
                end
            end
            default: begin
                state_next = ST_RX;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RX;
            rx_ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            rx_ready_reg <= (state_next == ST_RX);
        end
    end

    // packet capture; bytes past the first data byte are dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= 3'h0;
            for (int k = 0; k < REPLY_LEN; k++) begin
                pkt_reg[k] <= 8'h00;
            end
        end else if (rx_take) begin
            if (rx_cnt_reg <= IDX_DATA) begin
                pkt_reg[rx_cnt_reg] <= rx_byte.data;
            end
            if (rx_byte.last) begin
                rx_cnt_reg <= 3'h0;
            end else if (rx_cnt_reg <= IDX_DATA) begin
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
            end
        end else if (state_reg == ST_TX && tx_take && tx_last_reg) begin
            for (int k = 0; k < REPLY_LEN; k++) begin
                pkt_reg[k] <= 8'h00;
            end
        end
    end

    // address bytes never reach the line logic, only the echo
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_out_reg <= IO_OUT_RESET;
            io_oe_reg <= IO_OE_RESET;
        end else if (state_reg == ST_EXEC && is_io && is_write) begin
            io_out_reg <= pkt_reg[IDX_DATA][6:0];
            io_oe_reg <= {IO_WIDTH{1'b1}};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < REPLY_LEN; k++) begin
                reply_reg[k] <= 8'h00;
            end
        end else if (state_reg == ST_EXEC) begin
            reply_reg[IDX_OPIF] <= status_byte;
            reply_reg[IDX_SLAVE] <= pkt_reg[IDX_SLAVE];
            reply_reg[IDX_LENGTH] <= pkt_reg[IDX_LENGTH];
            reply_reg[IDX_REGADDR] <= pkt_reg[IDX_REGADDR];
            if (is_io && !is_write) begin
                reply_reg[IDX_DATA] <= {1'b0, io_sync};
            end else begin
                reply_reg[IDX_DATA] <= pkt_reg[IDX_DATA];
            end
        end
    end

    // reply is always five bytes; tx holds while the sink stalls
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_last_reg <= 1'b0;
            tx_idx_reg <= 3'h0;
        end else if (state_reg == ST_EXEC) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= status_byte;
            tx_last_reg <= 1'b0;
            tx_idx_reg <= 3'h1;
        end else if (tx_take) begin
            if (tx_last_reg) begin
                tx_valid_reg <= 1'b0;
                tx_last_reg <= 1'b0;
            end else begin
                tx_data_reg <= reply_reg[tx_idx_reg];
                tx_last_reg <= (tx_idx_reg == IDX_DATA);
                tx_idx_reg <= tx_idx_reg + 3'h1;
            end
        end
    end

    assign rx_ready = rx_ready_reg;
    assign tx_valid = tx_valid_reg;
    assign tx_byte = '{data: tx_data_reg, last: tx_last_reg};
    assign io_lines_out = io_out_reg;
    assign io_lines_oe = io_oe_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence exec_io_write_s;
        state_reg == ST_EXEC && is_io && is_write;
    endsequence

    sequence exec_io_read_s;
        state_reg == ST_EXEC && is_io && !is_write;
    endsequence

    line_drive_a: assert property (exec_io_write_s |=> io_out_reg == $past(pkt_reg[IDX_DATA][6:0]))
        else $error("lines do not follow the written data byte");
    line_select_a: assert property (state_reg == ST_EXEC && !is_io |=> $stable(io_out_reg))
        else $error("lines moved for a non-i/o interface");
    line_cause_a: assert property ($changed(io_out_reg) |-> $past(state_reg == ST_EXEC && is_io && is_write))
        else $error("lines changed without an i/o write");
    done_flag_a: assert property (state_reg == ST_EXEC && is_io |=> tx_valid_reg &&
        tx_data_reg == ($past(pkt_reg[IDX_OPIF]) | STAT_REQ_DONE))
        else $error("reply first byte lacks the completion flag");
    sample_reply_a: assert property (exec_io_read_s |=> reply_reg[IDX_DATA] == {1'b0, $past(io_sync)})
        else $error("read reply does not hold the sampled lines");
    top_bit_a: assert property (tx_valid_reg && tx_last_reg && reply_reg[IDX_OPIF] ==
        (INTF_IO | STAT_REQ_DONE) |-> !tx_data_reg[7])
        else $error("unused top bit not zero in read reply");
    // helper count of reply bytes taken, read only by the length check
    logic [2:0] reply_seen_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reply_seen_reg <= 3'h0;
        end else if (state_reg == ST_EXEC) begin
            reply_seen_reg <= 3'h0;
        end else if (tx_take && reply_seen_reg != 3'h7) begin
            reply_seen_reg <= reply_seen_reg + 3'h1;
        end
    end

    reply_length_a: assert property (tx_take |-> tx_last_reg == (reply_seen_reg == 3'h4))
        else $error("reply is not five bytes long");
    bad_request_a: assert property (state_reg == ST_EXEC && !intf_known |=> tx_data_reg[7])
        else $error("malformed request not flagged");
    rx_stall_a: assert property (state_reg != ST_RX |-> !rx_ready_reg)
        else $error("input accepted while a packet is in progress");
endmodule : gpio_packet_command_port
`default_nettype wire

// [host_model.sv]
// host-side model: sends command packets and collects replies
`timescale 1ns/1ps
`default_nettype none
module host_model
    import gpio_cmd_pkg::*;
(
    // clock
    input wire logic core_clk,
    // command stream
    output logic rx_valid,
    output gpio_cmd_pkg::pkt_byte_t rx_byte,
    input wire logic rx_ready,
    // reply stream
    input wire logic tx_valid,
    input wire gpio_cmd_pkg::pkt_byte_t tx_byte,
    output logic tx_ready
);
    // script time is scaled down; a real pause would cost far too many cycles
    localparam int CYCLES_PER_MS = 5;
    localparam int USER_WAIT = 4;
    logic [7:0] reply [5];
    logic last_seen;
    logic [7:0] cur_intf = INTF_IO;
    int lines_run = 0;
    initial begin
        rx_valid = 1'b0;
        rx_byte = '0;
        tx_ready = 1'b0;
    end
    // one whole packet per call, reads carry no data byte
    task automatic xfer(input logic [7:0] b0, input logic [7:0] slv, input logic [7:0] rga,
                        input logic [7:0] dat, input bit wd, input int st);
        logic [7:0] pkt [5];
        int n;
        int k;
        pkt = '{b0, slv, 8'h01, rga, dat}; // length always one
        n = wd ? 5 : 4;
        k = 0;
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_byte <= '{pkt[i], i == n - 1};
            @(posedge core_clk);
            while (rx_ready !== 1'b1 && k < 50) begin
                k++;
                @(posedge core_clk);
            end
        end
        // released bus shows the inverse, not a stale copy
        rx_valid <= 1'b0;
        rx_byte <= ~{pkt[n - 1], 1'b1};
        for (int i = 0; i < 5; i++) begin
            if (st > 0) begin
                tx_ready <= 1'b0;
                repeat (st) @(posedge core_clk);
            end
            tx_ready <= 1'b1;
            @(posedge core_clk);
            while (tx_valid !== 1'b1 && k < 100) begin
                k++;
                @(posedge core_clk);
            end
            reply[i] = tx_byte.data;
            last_seen = tx_byte.last;
        end
        tx_ready <= 1'b0;
    endtask : xfer

    // one script line per call, carriage return already stripped
    task automatic run_line(input string ln, input int st);
        logic [7:0] v [4];
        logic [7:0] b0;
        string kw;
        byte c;
        int nv;
        int p;
        lines_run++;
        v = '{8'h00, 8'h00, 8'h00, 8'h00};
        nv = 0;
        p = 2;
        if (ln.len() == 0) begin
            // a blank line still runs and replaces the shown result
            foreach (reply[i]) reply[i] = 8'h00;
            return;
        end
        c = ln.getc(0);
        case (c)
            "i": begin
                kw = ln.substr(2, ln.len() - 1);
                if (kw == "gpio") cur_intf = INTF_IO;
                else if (kw == "two_wire_standard_select") cur_intf = INTF_TWO_WIRE_STD;
                else if (kw == "two_wire_fast_select") cur_intf = INTF_TWO_WIRE_FAST;
                else if (kw == "four_wire_short_address_select") cur_intf = INTF_FOUR_WIRE_SHORT;
                else if (kw == "four_wire_long_address_select") cur_intf = INTF_FOUR_WIRE_LONG;
            end
            "w", "r": begin
                // single spaces part the hex bytes
                for (int i = 2; i <= ln.len(); i++) begin
                    if (i == ln.len() || ln.getc(i) == " ") begin
                        if (nv < 4) v[nv] = 8'(ln.substr(p, i - 1).atohex());
                        nv++;
                        p = i + 1;
                    end
                end
                b0 = (c == "w" ? OP_WRITE : 8'h00) | cur_intf;
                xfer(b0, v[0], v[1], c == "w" ? v[2] : 8'h00, c == "w", st);
            end
            "#": begin
                // rest of the line is ignored
            end
            "b": begin
                // no operands; a fixed wait stands for the user's go-ahead
                repeat (USER_WAIT) @(posedge core_clk);
            end
            "d": begin
                // decimal milliseconds, scaled; only approximate anyway
                repeat (ln.substr(2, ln.len() - 1).atoi() * CYCLES_PER_MS) @(posedge core_clk);
            end
            default: begin
            end
        endcase
    endtask : run_line
endmodule : host_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the packet-driven i/o port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpio_cmd_pkg::*;
    logic core_clk;
    logic rst_n;
    logic rx_valid;
    logic rx_ready;
    logic tx_valid;
    logic tx_ready;
    pkt_byte_t rx_byte;
    pkt_byte_t tx_byte;
    gpio_lines_t io_lines_in;
    gpio_lines_t io_lines_out;
    gpio_lines_t io_lines_oe;
    int n_errors = 0;
    int num_checks = 0;
    logic [7:0] model_out = 8'h00;
    logic wrote = 1'b0;
    logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h0b, 8'h28};

    gpio_packet_command_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .io_lines_in(io_lines_in), .io_lines_out(io_lines_out),
        .io_lines_oe(io_lines_oe));
    host_model i_host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

    always #5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic run(input logic [7:0] op, input logic [7:0] intf, input logic [7:0] dat,
                       input bit wd, input int st);
        logic [7:0] b0;
        logic [7:0] slv;
        logic [7:0] rga;
        logic [7:0] e [5];
        slv = 8'($urandom);
        rga = 8'($urandom);
        io_lines_in <= 7'($urandom);
        // lines pass a two-flop synchroniser before sampling
        repeat (3) @(posedge core_clk);
        b0 = op | intf;
        e = '{b0 | 8'h40, slv, 8'h01, rga, wd ? dat : 8'h00};
        if (b0[7:5] != 3'h0 || !(b0[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})) e[0] = b0 | 8'h80;
        else if (b0[3:0] == 4'h8) begin
            e[0] = b0 | 8'h20;
            if (op == OP_WRITE) begin
                model_out = dat & 8'h7f;
                wrote = 1'b1;
            end else e[4] = {1'b0, io_lines_in};
        end
        i_host.xfer(b0, slv, rga, dat, wd, st);
        for (int i = 0; i < 5; i++) check("reply byte", i_host.reply[i], e[i]);
        check("last flag", {7'h0, i_host.last_seen}, 8'h01);
        check("driven lines", {1'b0, io_lines_out}, model_out);
        check("line enables", {1'b0, io_lines_oe}, wrote ? 8'h7f : 8'h00);
    endtask : run

    initial begin
        #100us;
        n_errors++;
        complete_run();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        io_lines_in = '0;
        void'($urandom(32'hb9973f91));
        repeat (20) @(posedge core_clk);
        check("enables in reset", {1'b0, io_lines_oe}, 8'h00);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int t = 0; t < 12; t++) run(OP_WRITE, INTF_IO, t == 0 ? 8'h40 : 8'($urandom), 1'b1, t % 3);
        $display("test io write done");
        for (int t = 0; t < 12; t++) run(8'h00, INTF_IO, 8'h00, 1'b0, t % 4);
        $display("test io read done");
        for (int t = 0; t < 16; t++) run(t[0] ? OP_WRITE : 8'h00, codes[t / 2], 8'($urandom), t[0], 1);
        $display("test interface codes done");
        io_lines_in <= 7'($urandom);
        i_host.run_line("# drive only line 6", 0);
        i_host.run_line("i gpio", 0);
        i_host.run_line("w 00 00 40", 1);
        check("script write", {1'b0, io_lines_out}, 8'h40);
        i_host.run_line("d 2", 0);
        i_host.run_line("r 00 00 1", 0);
        check("script read status", i_host.reply[0], 8'h28);
        check("script read data", i_host.reply[4], {1'b0, io_lines_in});
        i_host.run_line("b", 0);
        i_host.run_line("i two_wire_fast_select", 0);
        i_host.run_line("w a0 05 aa", 2);
        check("script other intf", i_host.reply[0], 8'h52);
        check("script slave echo", i_host.reply[1], 8'ha0);
        i_host.run_line("", 0);
        check("blank line result", i_host.reply[0], 8'h00);
        check("lines run", 8'(i_host.lines_run), 8'h09);
        $display("test script done");
        rst_n <= 1'b0;
        @(posedge core_clk);
        // enables drop only through reset
        check("enables after reset", {1'b0, io_lines_oe}, 8'h00);
        rst_n <= 1'b1;
        model_out = 8'h00;
        wrote = 1'b0;
        @(posedge core_clk);
        run(8'h00, INTF_IO, 8'h00, 1'b0, 2);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
